// file: design/crcec_ahb_slave.sv
// AHB-Lite slave front end of the CRC engine registers
`timescale 1ns/100ps
module crcec_ahb_slave
    import crcec_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // Register side
    output crcec_wr_s        wr,
    output crcec_rd_s        rd,
    input  wire logic [31:0] rdata
);
    logic       accept;
    logic       wr_pend_q;
    logic       rd_pend_q;
    logic [7:0] addr_q;
    logic       ready_q;
    logic [31:0] rdata_q;

    assign accept = hsel & htrans[1] & hready;

    // Address phase capture; reads take one wait state so a write just
    // before them is always visible
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q    <= 8'h00;
        end else begin
            wr_pend_q <= accept & hwrite;
            rd_pend_q <= accept & ~hwrite;
            if (accept) begin
                addr_q <= haddr[7:0];
            end
        end
    end

    // Ready and read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ready_q <= 1'b1;
            rdata_q <= 32'h00000000;
        end else begin
            ready_q <= ~(accept & ~hwrite);
            if (rd_pend_q) begin
                rdata_q <= rdata;
            end
        end
    end

    assign wr        = '{valid: wr_pend_q, addr: addr_q, data: hwdata};
    assign rd        = '{valid: rd_pend_q, addr: addr_q};
    assign hreadyout = ready_q;
    assign hrdata    = rdata_q;
    assign hresp     = 1'b0;   // Always OKAY
endmodule

// file: design/crcec_shifter.sv
// Serial CRC shifter and accumulator
`timescale 1ns/100ps
module crcec_shifter
    import crcec_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // Control
    input  wire logic        load,
    input  wire logic        abort,
    input  wire logic [15:0] word,
    input  wire crcec_cfg_s  cfg,
    // Accumulator writes, high and low byte
    input  wire logic [1:0]  acc_we,
    input  wire logic [7:0]  acc_wdata,
    // State
    output logic [15:0]      acc,
    output logic [15:0]      shift,
    output logic             busy,
    output logic             done
);
    crcec_state_e state_q;
    logic [3:0]   cnt_q;
    logic [15:0]  sh_q;
    logic [15:0]  acc_q;
    logic [15:0]  acc_d;
    logic         done_q;
    logic         in_bit;

    // One bit step; augmented mode feeds data into the low end when shifting left, the top polynomial bit when shifting right
    function automatic logic [15:0] crc_step(input logic [15:0] a,
                                             input logic b,
                                             input crcec_cfg_s c);
        logic        fb;
        logic [15:0] n;
        if (!c.shift_direction_select) begin
            fb = c.zero_augment_select ? a[c.poly_length_field] : a[c.poly_length_field] ^ b;
            n  = {a[14:0], c.zero_augment_select & b};
        end else begin
            fb = c.zero_augment_select ? a[0] : a[0] ^ b;
            n  = {1'b0, a[15:1]} | ((c.zero_augment_select & b) ? (16'h0001 << c.poly_length_field) : 16'h0000);
        end
        if (fb) begin
            n = n ^ c.poly;
        end
        return n & len_mask(c.poly_length_field);
    endfunction

    assign in_bit = cfg.shift_direction_select ? sh_q[0] : sh_q[cfg.word_length_field];

    // Sequencer; config is live, so software must not change it mid-word
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= SH_IDLE;
            cnt_q   <= 4'h0;
            sh_q    <= 16'h0000;
            done_q  <= 1'b0;
        end else begin
            done_q <= 1'b0;
            if (abort) begin
                state_q <= SH_IDLE;
            end else begin
                case (state_q)
                    SH_IDLE: begin
                        if (load) begin
                            state_q <= SH_RUN;
                            cnt_q   <= cfg.word_length_field;
                            sh_q    <= word;
                        end
                    end
                    SH_RUN: begin
                        sh_q  <= cfg.shift_direction_select ? {1'b0, sh_q[15:1]} : {sh_q[14:0], 1'b0};
                        cnt_q <= cnt_q - 4'h1;
                        if (cnt_q == 4'h0) begin
                            state_q <= SH_IDLE;
                            done_q  <= 1'b1;
                        end
                    end
                    default: state_q <= SH_IDLE;
                endcase
            end
        end
    end

    // Accumulator; a software write wins over a step in the same cycle
    always_comb begin
        acc_d = (state_q == SH_RUN && !abort) ? crc_step(acc_q, in_bit, cfg) : acc_q;
        if (acc_we[1]) begin
            acc_d[15:8] = acc_wdata;
        end
        if (acc_we[0]) begin
            acc_d[7:0] = acc_wdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_q <= 16'h0000;
        end else begin
            acc_q <= acc_d;
        end
    end

    assign acc   = acc_q;
    assign shift = sh_q;
    assign busy  = (state_q == SH_RUN);
    assign done  = done_q;
endmodule

// file: design/crcec_top.sv
// CRC engine register block with AHB-Lite access and interrupt
// Functional notes
// - Upper nibble of the length register holds word length minus one.
// - Lower nibble of the length register holds polynomial length minus one.
// - Writing the data low byte queues the data word for the shifter.
// - Data is a 16-bit read/write pair of high and low byte.
// - All implemented control bits reset to zero on every reset.
// - Control bits 3 and 2 read zero and ignore writes.
// - Accumulator is read/write as high and low byte, reset zero.
// - Shifter contents are read-only as high and low byte, reset zero.
// - Polynomial bits 15..1 are writable and bit 0 always reads one.
`timescale 1ns/100ps
`include "crcec_params.svh"
module crcec_top
    import crcec_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic [31:0]      hrdata,
    output logic             hresp,
    // Interrupt
    output logic             irq
);
    crcec_wr_s   wr;
    crcec_rd_s   rd;
    logic [31:0] rdata;
    crcec_cfg_s  cfg;

    // Control state
    logic        en_q;
    logic        go_q;
    logic        zero_augment_select_q;
    logic        shift_direction_select_q;
    logic        full_q;
    logic [7:0]  len_q;
    logic [15:0] dat_q;
    logic [15:1] poly_q;
    logic [1:0]  irq_st_q;
    logic [1:0]  irq_mask_q;
    logic        irq_q;

    // Engine view
    logic [15:0] acc;
    logic [15:0] shift;
    logic        sh_busy;
    logic        sh_done;
    logic        start;
    logic        busy_view;
    logic [7:0]  ctrl_view;
    logic [15:0] poly_view;
    logic [1:0]  irq_ev;
    logic [1:0]  irq_st_d;

    // Write strobes per register
    function automatic logic hit(input crcec_wr_s w, input logic [7:0] a);
        return w.valid && (w.addr == a);
    endfunction

    crcec_ahb_slave u_bus (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hwdata    (hwdata),
        .hready    (hready),
        .hreadyout (hreadyout),
        .hrdata    (hrdata),
        .hresp     (hresp),
        .wr        (wr),
        .rd        (rd),
        .rdata     (rdata)
    );

    // Shifter configuration from the registers
    assign cfg = '{
        word_length_field:   len_q[`CRCEC_WORD_LENGTH_FIELD_HI:`CRCEC_WORD_LENGTH_FIELD_LO],
        poly_length_field:   len_q[`CRCEC_POLY_LENGTH_FIELD_HI:`CRCEC_POLY_LENGTH_FIELD_LO],
        zero_augment_select:   zero_augment_select_q,
        shift_direction_select: shift_direction_select_q,
        poly:   poly_view
    };

    // Pending data moves to the shifter once enabled and started
    assign start = en_q & go_q & full_q & ~sh_busy;

    crcec_shifter u_shift (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .load      (start),
        .abort     (~en_q),
        .word      (dat_q),
        .cfg       (cfg),
        .acc_we    ({hit(wr, `CRCEC_OFF_ACC_HI), hit(wr, `CRCEC_OFF_ACC_LO)}),
        .acc_wdata (wr.data[7:0]),
        .acc       (acc),
        .shift     (shift),
        .busy      (sh_busy),
        .done      (sh_done)
    );

    // Control register; a disabled engine is held idle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_q     <= 1'b0;
            go_q     <= 1'b0;
            zero_augment_select_q   <= 1'b0;
            shift_direction_select_q <= 1'b0;
        end else if (hit(wr, `CRCEC_OFF_CTRL)) begin
            en_q     <= wr.data[`CRCEC_B_EN];
            go_q     <= wr.data[`CRCEC_B_GO];
            zero_augment_select_q   <= wr.data[`CRCEC_B_ZERO_AUGMENT_SELECT];
            shift_direction_select_q <= wr.data[`CRCEC_B_SHIFT_DIRECTION_SELECT];
        end
    end

    // Data full flag; a new low-byte write wins over the hand-off
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            full_q <= 1'b0;
        end else if (hit(wr, `CRCEC_OFF_DAT_LO)) begin
            full_q <= 1'b1;
        end else if (start) begin
            full_q <= 1'b0;
        end
    end

    // Length configuration
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            len_q <= `CRCEC_RST_BYTE;
        end else if (hit(wr, `CRCEC_OFF_LEN)) begin
            len_q <= wr.data[7:0];
        end
    end

    // Data pair; defined reset value although software must load it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dat_q <= `CRCEC_RST_WORD;
        end else begin
            if (hit(wr, `CRCEC_OFF_DAT_HI)) begin
                dat_q[15:8] <= wr.data[7:0];
            end
            if (hit(wr, `CRCEC_OFF_DAT_LO)) begin
                dat_q[7:0] <= wr.data[7:0];
            end
        end
    end

    // Polynomial terms; the constant term is always present
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            poly_q <= `CRCEC_RST_POLY;
        end else begin
            if (hit(wr, `CRCEC_OFF_POLY_HI)) begin
                poly_q[15:8] <= wr.data[7:0];
            end
            if (hit(wr, `CRCEC_OFF_POLY_LO)) begin
                poly_q[7:1] <= wr.data[7:1];
            end
        end
    end

    assign poly_view = {poly_q, 1'b1};

    // Events: word shifted, data register emptied
    assign irq_ev = {start, sh_done};

    // Sticky status, write one to clear; an event wins over the clear
    always_comb begin
        irq_st_d = irq_st_q;
        if (hit(wr, `CRCEC_OFF_IRQ_ST)) begin
            irq_st_d = irq_st_d & ~wr.data[1:0];
        end
        irq_st_d = irq_st_d | irq_ev;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_st_q   <= `CRCEC_RST_IRQ;
            irq_mask_q <= `CRCEC_RST_IRQ;
            irq_q      <= 1'b0;
        end else begin
            irq_st_q <= irq_st_d;
            if (hit(wr, `CRCEC_OFF_IRQ_MASK)) begin
                irq_mask_q <= wr.data[1:0];
            end
            irq_q <= |(irq_st_d & irq_mask_q);
        end
    end

    assign irq = irq_q;

    // Busy covers a word in flight and one waiting for the shifter
    assign busy_view = sh_busy | (en_q & go_q & full_q);

    // Control readback; bits 3 and 2 are absent
    always_comb begin
        ctrl_view                  = 8'h00;
        ctrl_view[`CRCEC_B_EN]     = en_q;
        ctrl_view[`CRCEC_B_GO]     = go_q;
        ctrl_view[`CRCEC_B_BUSY]   = busy_view;
        ctrl_view[`CRCEC_B_ZERO_AUGMENT_SELECT]   = zero_augment_select_q;
        ctrl_view[`CRCEC_B_SHIFT_DIRECTION_SELECT] = shift_direction_select_q;
        ctrl_view[`CRCEC_B_FULL]   = full_q;
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        rdata = 32'h00000000;
        case (rd.addr)
            `CRCEC_OFF_CTRL:     rdata[7:0] = ctrl_view;
            `CRCEC_OFF_LEN:      rdata[7:0] = len_q;
            `CRCEC_OFF_DAT_HI:   rdata[7:0] = dat_q[15:8];
            `CRCEC_OFF_DAT_LO:   rdata[7:0] = dat_q[7:0];
            `CRCEC_OFF_ACC_HI:   rdata[7:0] = acc[15:8];
            `CRCEC_OFF_ACC_LO:   rdata[7:0] = acc[7:0];
            `CRCEC_OFF_SHF_HI:   rdata[7:0] = shift[15:8];
            `CRCEC_OFF_SHF_LO:   rdata[7:0] = shift[7:0];
            `CRCEC_OFF_POLY_HI:  rdata[7:0] = poly_view[15:8];
            `CRCEC_OFF_POLY_LO:  rdata[7:0] = poly_view[7:0];
            `CRCEC_OFF_IRQ_ST:   rdata[1:0] = irq_st_q;
            `CRCEC_OFF_IRQ_MASK: rdata[1:0] = irq_mask_q;
            default:             rdata = 32'h00000000;
        endcase
    end

    // Checks: cycles the shifter has run for the current word
    logic [4:0] run_cnt_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            run_cnt_q <= 5'h00;
        end else if (start) begin
            run_cnt_q <= 5'h00;
        end else if (sh_busy) begin
            run_cnt_q <= run_cnt_q + 5'h01;
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_ctrl_reset: assert property ($rose(hresetn) |-> ctrl_view == 8'h00 && len_q == 8'h00)
        else $error("control not zero after reset");

    a_unimpl_zero: assert property (ctrl_view[3:2] == 2'b00)
        else $error("unimplemented control bits read nonzero");

    a_len_write: assert property (hit(wr, `CRCEC_OFF_LEN)
        |=> cfg.word_length_field == $past(wr.data[7:4]) && cfg.poly_length_field == $past(wr.data[3:0]))
        else $error("length fields not taken from write");

    a_word_length: assert property (sh_done |-> run_cnt_q == {1'b0, cfg.word_length_field} + 5'h01)
        else $error("word shifted for wrong bit count");

    a_poly_width: assert property (sh_done |-> (acc & ~len_mask(cfg.poly_length_field)) == 16'h0000)
        else $error("accumulator wider than polynomial");

    a_low_fills: assert property (hit(wr, `CRCEC_OFF_DAT_LO) |=> full_q)
        else $error("low byte write did not mark data full");

    a_start_loads: assert property (start && en_q |=> sh_busy && shift == $past(dat_q))
        else $error("shifter not loaded from data pair");

    a_data_high: assert property (hit(wr, `CRCEC_OFF_DAT_HI)
        |=> dat_q[15:8] == $past(wr.data[7:0]))
        else $error("data high byte not stored");

    a_busy_pending: assert property (en_q && go_q && full_q |-> ctrl_view[`CRCEC_B_BUSY])
        else $error("busy low with data pending");

    // An enabling write in this cycle may legally start a word two cycles on
    a_disable_idle: assert property (!en_q && !hit(wr, `CRCEC_OFF_CTRL)
        |=> !sh_busy ##1 !sh_busy)
        else $error("shifter ran while disabled");

    a_acc_write: assert property (hit(wr, `CRCEC_OFF_ACC_LO) |=> acc[7:0] == $past(wr.data[7:0]))
        else $error("accumulator low byte not written");

    a_shift_ro: assert property (hit(wr, `CRCEC_OFF_SHF_LO) && !sh_busy && !start
        |=> $stable(shift))
        else $error("shifter view changed by a write");

    a_poly_lsb: assert property (hit(wr, `CRCEC_OFF_POLY_LO) |=> poly_view[0] == 1'b1
        && poly_view[7:1] == $past(wr.data[7:1]))
        else $error("polynomial low byte wrong");

    a_irq_level: assert property (irq_ev[`CRCEC_IRQ_DONE] && irq_mask_q[`CRCEC_IRQ_DONE]
        && !hit(wr, `CRCEC_OFF_IRQ_MASK) |=> irq ##1 irq)
        else $error("masked-in event did not raise interrupt");

    c_word_done: cover property (start ##[1:16] sh_done);
    c_back_to_back: cover property (sh_done ##[1:4] start);
    c_irq_clear: cover property (irq ##[1:8] !irq);
    c_right_shift: cover property (shift_direction_select_q && sh_done);

    // Narrow transfers are treated as full words
    logic unused_hsize;
    assign unused_hsize = ^hsize;
endmodule

// file: include/crcec_params.svh
// Register offsets, field positions and reset values of the CRC engine
`ifndef CRCEC_PARAMS_SVH
`define CRCEC_PARAMS_SVH

// Byte offsets on the register bus
`define CRCEC_OFF_CTRL     8'h00
`define CRCEC_OFF_LEN      8'h04
`define CRCEC_OFF_DAT_HI   8'h08
`define CRCEC_OFF_DAT_LO   8'h0C
`define CRCEC_OFF_ACC_HI   8'h10
`define CRCEC_OFF_ACC_LO   8'h14
`define CRCEC_OFF_SHF_HI   8'h18
`define CRCEC_OFF_SHF_LO   8'h1C
`define CRCEC_OFF_POLY_HI  8'h20
`define CRCEC_OFF_POLY_LO  8'h24
`define CRCEC_OFF_IRQ_ST   8'h28
`define CRCEC_OFF_IRQ_MASK 8'h2C

// Fields of crc_control_main
`define CRCEC_B_EN     7
`define CRCEC_B_GO     6
`define CRCEC_B_BUSY   5
`define CRCEC_B_ZERO_AUGMENT_SELECT   4
`define CRCEC_B_SHIFT_DIRECTION_SELECT 1
`define CRCEC_B_FULL   0

// Fields of crc_length_config
`define CRCEC_WORD_LENGTH_FIELD_HI 7
`define CRCEC_WORD_LENGTH_FIELD_LO 4
`define CRCEC_POLY_LENGTH_FIELD_HI 3
`define CRCEC_POLY_LENGTH_FIELD_LO 0

// Interrupt status bits
`define CRCEC_IRQ_DONE  0
`define CRCEC_IRQ_TAKEN 1

// Reset values
`define CRCEC_RST_BYTE 8'h00
`define CRCEC_RST_WORD 16'h0000
`define CRCEC_RST_POLY 15'h0000
`define CRCEC_RST_IRQ  2'h0

`endif

// file: include/crcec_pkg.sv
// Types and shared functions of the CRC engine
package crcec_pkg;

    // Shifter sequencing
    typedef enum logic {
        SH_IDLE = 1'b0,
        SH_RUN  = 1'b1
    } crcec_state_e;

    // Register write request from the bus slave
    typedef struct packed {
        logic        valid;
        logic [7:0]  addr;
        logic [31:0] data;
    } crcec_wr_s;

    // Register read request from the bus slave
    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
    } crcec_rd_s;

    // Shifter configuration
    typedef struct packed {
        logic [3:0]  word_length_field;
        logic [3:0]  poly_length_field;
        logic        zero_augment_select;
        logic        shift_direction_select;
        logic [15:0] poly;
    } crcec_cfg_s;

    // Mask of the bits inside a polynomial of length n+1
    function automatic logic [15:0] len_mask(input logic [3:0] n);
        return 16'hFFFF >> (4'hF - n);
    endfunction

endpackage

// file: tb/test_crc_engine_control_registers.sv
// Register-level self-checking bench for the CRC engine block
`timescale 1ns/100ps
`include "crcec_params.svh"
module test_crc_engine_control_registers;
    // Bus and interrupt signals
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    logic        irq;
    // Bookkeeping
    int          err_count;
    int          check_count;
    int          i;
    logic [31:0] rv;
    logic [7:0]  exp_crc;

    // Single slave, so its ready is the bus ready
    crcec_top u_dut (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .hsel      (hsel),
        .haddr     (haddr),
        .htrans    (htrans),
        .hwrite    (hwrite),
        .hsize     (hsize),
        .hwdata    (hwdata),
        .hready    (hreadyout),
        .hreadyout (hreadyout),
        .hrdata    (hrdata),
        .hresp     (hresp),
        .irq       (irq)
    );

    // 200 MHz clock
    always #2.5 hclk = ~hclk;

    // Verdict and end of run
    task automatic report_and_stop();
        if (err_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Word comparison, four-state exact
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask

    // Waits for ready under a bound so a stuck slave cannot hang the run
    task automatic wait_rdy();
        int n;
        for (n = 0; n < 64; n++) begin
            @(posedge hclk);
            if (hreadyout === 1'b1) break;
        end
        if (n == 64) begin
            err_count++;
            report_and_stop();
        end
    endtask

    // One single AHB-Lite transfer: address phase, then data phase
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel   <= 1'b1;
        haddr  <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] dummy;
        ahb(1'b1, a, d, dummy);
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input string name);
        logic [31:0] d;
        ahb(1'b0, a, 32'h00000000, d);
        chk(name, exp, d);
    endtask

    // Polls status until the word-done bit shows, bounded by a retry count
    task automatic wait_done();
        for (i = 0; i < 20; i++) begin
            ahb(1'b0, `CRCEC_OFF_IRQ_ST, 32'h0, rv);
            if (rv[0] === 1'b1) break;
        end
    endtask

    // Reset held for three cycles, released just after an edge
    task automatic do_reset();
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask

    // Plain MSB-first CRC-8, no augmentation
    function automatic logic [7:0] crc8(input logic [7:0] d, input logic [7:0] p);
        logic [7:0] c;
        logic       fb;
        c = 8'h00;
        for (int k = 7; k >= 0; k--) begin
            fb = c[7] ^ d[k];
            c = {c[6:0], 1'b0} ^ (fb ? p : 8'h00);
        end
        return c;
    endfunction

    // Main sequence
    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h00000000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h00000000;
        err_count = 0;
        check_count = 0;
        do_reset();
        // Reset values
        rchk(`CRCEC_OFF_CTRL, 32'h00, "ctrl");
        rchk(`CRCEC_OFF_LEN, 32'h00, "len");
        rchk(`CRCEC_OFF_ACC_HI, 32'h00, "acc_hi");
        rchk(`CRCEC_OFF_ACC_LO, 32'h00, "acc_lo");
        rchk(`CRCEC_OFF_SHF_HI, 32'h00, "shf_hi");
        rchk(`CRCEC_OFF_SHF_LO, 32'h00, "shf_lo");
        rchk(`CRCEC_OFF_POLY_LO, 32'h01, "poly_lo");
        chk("irq", 32'h0, {31'h0, irq});
        chk("hresp", 32'h0, {31'h0, hresp});
        // Read-only and unimplemented control bits keep zero with full data path empty
        wreg(`CRCEC_OFF_CTRL, 32'hFF);
        rchk(`CRCEC_OFF_CTRL, 32'hD2, "ctrl_ff");
        wreg(`CRCEC_OFF_CTRL, 32'h00);
        wreg(`CRCEC_OFF_LEN, 32'hA5);
        rchk(`CRCEC_OFF_LEN, 32'hA5, "len_a5");
        wreg(`CRCEC_OFF_POLY_HI, 32'h5A);
        rchk(`CRCEC_OFF_POLY_HI, 32'h5A, "poly_hi");
        wreg(`CRCEC_OFF_POLY_LO, 32'hFE);
        rchk(`CRCEC_OFF_POLY_LO, 32'hFF, "poly_lo_fe");
        wreg(`CRCEC_OFF_SHF_LO, 32'hFF);
        rchk(`CRCEC_OFF_SHF_LO, 32'h00, "shf_ro");
        wreg(`CRCEC_OFF_ACC_HI, 32'hAB);
        wreg(`CRCEC_OFF_ACC_LO, 32'hCD);
        rchk(`CRCEC_OFF_ACC_HI, 32'hAB, "acc_hi_w");
        rchk(`CRCEC_OFF_ACC_LO, 32'hCD, "acc_lo_w");
        wreg(8'h30, 32'hFF);
        rchk(8'h30, 32'h00, "unmapped");
        // One 8-bit word through an 8-bit polynomial, left shift
        wreg(`CRCEC_OFF_ACC_HI, 32'h00);
        wreg(`CRCEC_OFF_ACC_LO, 32'h00);
        wreg(`CRCEC_OFF_LEN, 32'h77);
        wreg(`CRCEC_OFF_POLY_HI, 32'h00);
        wreg(`CRCEC_OFF_POLY_LO, 32'h07);
        wreg(`CRCEC_OFF_DAT_HI, 32'h12);
        wreg(`CRCEC_OFF_DAT_LO, 32'h34);
        rchk(`CRCEC_OFF_DAT_HI, 32'h12, "dat_hi");
        rchk(`CRCEC_OFF_DAT_LO, 32'h34, "dat_lo");
        rchk(`CRCEC_OFF_CTRL, 32'h01, "ctrl_full");
        wreg(`CRCEC_OFF_CTRL, 32'hC0);
        wait_done();
        chk("status", 32'h03, rv);
        exp_crc = crc8(8'h34, 8'h07);
        rchk(`CRCEC_OFF_ACC_LO, {24'h0, exp_crc}, "crc");
        rchk(`CRCEC_OFF_ACC_HI, 32'h00, "crc_hi");
        rchk(`CRCEC_OFF_CTRL, 32'hC0, "ctrl_idle");
        // Interrupt: masked, unmasked, then cleared by writing ones
        chk("irq_masked", 32'h0, {31'h0, irq});
        wreg(`CRCEC_OFF_IRQ_MASK, 32'h01);
        rchk(`CRCEC_OFF_IRQ_MASK, 32'h01, "mask");
        chk("irq_set", 32'h1, {31'h0, irq});
        wreg(`CRCEC_OFF_IRQ_ST, 32'h03);
        rchk(`CRCEC_OFF_IRQ_ST, 32'h00, "status_clr");
        chk("irq_clr", 32'h0, {31'h0, irq});
        // Disable in mid-word: word taken, never completed
        wreg(`CRCEC_OFF_DAT_LO, 32'h55);
        wreg(`CRCEC_OFF_CTRL, 32'h40);
        rchk(`CRCEC_OFF_CTRL, 32'h40, "ctrl_abort");
        rchk(`CRCEC_OFF_IRQ_ST, 32'h02, "st_abort");
        // Right shift, LSB first: data 01 through terms 8D (bit 0 forced) gives CC
        wreg(`CRCEC_OFF_ACC_HI, 32'h00);
        wreg(`CRCEC_OFF_ACC_LO, 32'h00);
        wreg(`CRCEC_OFF_POLY_LO, 32'h8C);
        wreg(`CRCEC_OFF_DAT_LO, 32'h01);
        wreg(`CRCEC_OFF_CTRL, 32'hC2);
        wait_done();
        chk("status_right", 32'h03, rv);
        rchk(`CRCEC_OFF_ACC_LO, 32'hCC, "crc_right");
        chk("irq_done", 32'h1, {31'h0, irq});
        // Second reset after a length write, with the shifter idle
        wreg(`CRCEC_OFF_LEN, 32'hFF);
        do_reset();
        rchk(`CRCEC_OFF_LEN, 32'h00, "len_rst2");
        rchk(`CRCEC_OFF_CTRL, 32'h00, "ctrl_rst2");
        chk("irq_rst2", 32'h0, {31'h0, irq});
        report_and_stop();
    end

    // Watchdog: the sequence needs well under a thousand cycles
    initial begin
        #20000;
        err_count++;
        report_and_stop();
    end
endmodule
